// ===== shared/fsf_map.vh
// Constants for the fail-safe clock start-up and flag block.
// Included by bare name from the design files; definitions only.
`ifndef FSF_MAP_VH
`define FSF_MAP_VH

// ----------------------------------------
// Register addresses (plain port, 4 bits)
// ----------------------------------------
`define FSF_ADDR_FLAGS 4'h0
`define FSF_ADDR_MASK 4'h1
`define FSF_ADDR_CTRL 4'h2
`define FSF_ADDR_STAT 4'h3

// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define FSF_BIT_OSC_FAIL 7
`define FSF_BIT_CMP_TWO 6
`define FSF_BIT_CMP_ONE 5
`define FSF_BIT_NVM_DONE 4
`define FSF_BIT_BUS_COLL 3
`define FSF_BIT_CCP_TWO 0
`define FSF_FLAGS_IMPL 8'hf9
`define FSF_FLAGS_RESET 8'h00

// ----------------------------------------
// Control register fields and reset value
// ----------------------------------------
`define FSF_CTRL_MON_EN 0
`define FSF_CTRL_SCS_LO 1
`define FSF_CTRL_SCS_HI 2
`define FSF_CTRL_RESET 8'h00

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define FSF_STAT_OST_DONE 0
`define FSF_STAT_MON_ACT 1
`define FSF_STAT_ON_INT 2
`define FSF_STAT_FAILED 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSF_SAMPLE_DIV 64
`define FSF_OST_CYCLES 1024
`endif

// ===== sim/fsf_top_asserts.sv
// Checker for the fail-safe block, sees only top-level ports.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module fsf_top_asserts (
   input wire logic sys_clk_in, // System clock
   input wire logic rst_n_in, // Reset, active low
   input wire logic ce_in, // Clock enable
   input wire logic [3:0] addr_in, // Register address
   input wire logic [7:0] wdata_in, // Write data
   input wire logic wr_in, // Write strobe
   input wire logic rd_in, // Read strobe
   input wire logic [7:0] rdata_out, // Read data
   input wire logic irq_out, // Interrupt level
   input wire logic wake_in, // Wake pulse
   input wire logic sleep_in, // Sleep pulse
   input wire logic fail_out, // Fail condition
   input wire logic use_internal_out // Internal clock in use
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Read data only stands in the cycle after a read
   read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_zero_a: assert property (rd_in && ce_in && addr_in > 4'h3 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   flag_gap_a: assert property (rd_in && ce_in && addr_in == 4'h0 |=> rdata_out[2:1] == 2'b00)
      else $error("unused flag bits not zero");
   fail_internal_a: assert property (fail_out |-> use_internal_out)
      else $error("failed but not on internal clock");
   sleep_clear_a: assert property (sleep_in && ce_in |-> ##[1:3] !fail_out)
      else $error("sleep did not clear failure");
   wake_clear_a: assert property (wake_in && ce_in |-> ##[1:3] !fail_out)
      else $error("wake did not clear failure");
   stat_fail_a: assert property (rd_in && ce_in && addr_in == 4'h3 |=> rdata_out[3] == fail_out)
      else $error("status fail bit wrong");
   // Excludes a failure, whose flag is set again by hardware
   read_clear_a: assert property (rd_in && ce_in && addr_in == 4'h3 && !fail_out |=> !irq_out)
      else $error("status read left interrupt high");
   mask_off_a: assert property (wr_in && ce_in && addr_in == 4'h1 && wdata_in == 8'h00 |=> ##1 !irq_out)
      else $error("masked interrupt still high");
endmodule
bind fsf_top fsf_top_asserts fsf_top_asserts_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
   .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .irq_out(irq_out), .wake_in(wake_in), .sleep_in(sleep_in),
   .fail_out(fail_out), .use_internal_out(use_internal_out));

// ===== sim/fsf_top_tb.sv
// Self-checking bench for the fail-safe block and its flag register.
// Assumes the timer is shortened to 8 edges for simulation.
`timescale 1ns/1ps
`include "fsf_map.vh"
module fsf_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, wake = 1'b0, sleep = 1'b0;
   logic lf = 1'b0, run = 1'b1, ext_clk, irq, use_int, fail;
   logic [3:0] addr = 4'h0; // Register address
   logic [7:0] wdata = 8'h00, rdata, got;
   logic [4:0] ev = 5'h00; // Flag events, ccp two in bit 0
   logic [1:0] mode = 2'h0; // Oscillator mode
   logic [7:0] fbit [5] = '{8'h01, 8'h08, 8'h10, 8'h20, 8'h40};
   int error_cnt = 0, total_checks = 0, n;
   // ----------------------------------------
   // Clocks and instances
   // ----------------------------------------
   initial forever #50 clk = ~clk;
   // Slow internal oscillator, 1 us, well below a quarter of the system clock
   initial forever #500 lf = ~lf;
   fsf_top #(.OST_CYCLES(8)) fsf_top_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .irq_out(irq), .ext_clk_in(ext_clk), .lf_osc_in(lf), .osc_mode_in(mode),
      .wake_in(wake), .sleep_in(sleep), .cmp_two_in(ev[4]), .cmp_one_in(ev[3]),
      .nvm_done_in(ev[2]), .bus_coll_in(ev[1]), .ccp_two_in(ev[0]),
      .use_internal_out(use_int), .fail_out(fail));
   fsf_xosc_model fsf_xosc_model_inst (.run_in(run), .clk_out(ext_clk));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Each task ends one edge after its strobe drops, so strobes never double up
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask
   task automatic chk(input logic [7:0] g, e, m);
      total_checks++;
      if ((g & m) !== (e & m)) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h mask %h", $time, g, e, m);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] e, m);
      rd_reg(a, got);
      chk(got, e, m);
   endtask
   task automatic pulse(input logic [4:0] e, input logic w, s);
      ev <= e;
      wake <= w;
      sleep <= s;
      @(posedge clk);
      ev <= 5'h00;
      wake <= 1'b0;
      sleep <= 1'b0;
      @(posedge clk);
   endtask
   // Polls status under a bound; the reads also clear flags
   task automatic wait_stat(input logic [7:0] e, m);
      for (int k = 0; k < 3000; k++) begin
         rd_reg(`FSF_ADDR_STAT, got);
         if ((got & m) === (e & m)) break;
      end
      chk(got, e, m);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      #5_000_000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Flag register access and unused bits
      rchk(`FSF_ADDR_FLAGS, 8'h00, 8'hff);
      wr_reg(`FSF_ADDR_FLAGS, 8'hff);
      rchk(`FSF_ADDR_FLAGS, 8'hf9, 8'hff);
      rd_reg(`FSF_ADDR_STAT, got);
      for (int i = 0; i < 5; i++) begin
         pulse(5'h01 << i, 1'b0, 1'b0);
         chk({7'h00, irq}, 8'h00, 8'h01);
         rchk(`FSF_ADDR_FLAGS, fbit[i], 8'hff);
         rd_reg(`FSF_ADDR_STAT, got);
      end
      // Interrupt raised, masked and cleared
      wr_reg(`FSF_ADDR_MASK, 8'h40);
      pulse(5'h10, 1'b0, 1'b0);
      chk({7'h00, irq}, 8'h01, 8'h01);
      wr_reg(`FSF_ADDR_MASK, 8'h00);
      #1;
      chk({7'h00, irq}, 8'h00, 8'h01);
      wr_reg(`FSF_ADDR_MASK, 8'h40);
      #1;
      chk({7'h00, irq}, 8'h01, 8'h01);
      rd_reg(`FSF_ADDR_STAT, got);
      chk({7'h00, irq}, 8'h00, 8'h01);
      wr_reg(4'h9, 8'hff);
      rchk(4'h9, 8'h00, 8'hff);
      rchk(`FSF_ADDR_MASK, 8'h40, 8'hff);
      // Reset in mid-run clears all flags and restarts the timer
      pulse(5'h1f, 1'b0, 1'b0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wr_reg(`FSF_ADDR_CTRL, 8'h01);
      rchk(`FSF_ADDR_STAT, 8'h04, 8'h07);
      rchk(`FSF_ADDR_FLAGS, 8'h00, 8'hff);
      wait_stat(8'h03, 8'h0b);
      // Dead oscillator is caught within one to three sample half-cycles
      wr_reg(`FSF_ADDR_MASK, 8'h80);
      run <= 1'b0;
      for (n = 0; n < 3000 && fail !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      chk({7'h00, n >= 300 && n <= 1000}, 8'h01, 8'h01);
      chk({6'h00, use_int, irq}, 8'h03, 8'h03);
      rchk(`FSF_ADDR_FLAGS, 8'h80, 8'hff);
      pulse(5'h00, 1'b0, 1'b1);
      rchk(`FSF_ADDR_STAT, 8'h00, 8'h09);
      run <= 1'b1;
      wait_stat(8'h03, 8'h0b);
      pulse(5'h00, 1'b1, 1'b0);
      rchk(`FSF_ADDR_STAT, 8'h00, 8'h01);
      wait_stat(8'h03, 8'h0b);
      wr_reg(`FSF_ADDR_CTRL, 8'h03);
      rchk(`FSF_ADDR_CTRL, 8'h03, 8'hff);
      rchk(`FSF_ADDR_STAT, 8'h00, 8'h01);
      wait_stat(8'h03, 8'h0b);
      // Clock-input and RC modes skip the timer
      for (int m = 1; m < 3; m++) begin
         mode <= m[1:0];
         run <= 1'b0;
         pulse(5'h00, 1'b1, 1'b0);
         rchk(`FSF_ADDR_STAT, 8'h03, 8'h03);
      end
      print_verdict();
   end
endmodule

// ===== sim/fsf_xosc_model.sv
// External oscillator model for the fail-safe block.
// Assumes the bench starts and stops it through run_in.
`timescale 1ns/1ps
module fsf_xosc_model #(
   parameter HALF_NS = 200
) (
   input wire logic run_in, // High while the source oscillates
   output logic clk_out // Oscillator pin
);
   // ----------------------------------------
   // Oscillator
   // ----------------------------------------
   // A dead source freezes at its last level, so no edge reaches the pin
   initial begin
      clk_out = 1'b0;
      forever begin
         #(HALF_NS);
         if (run_in) begin
            clk_out = ~clk_out;
         end
      end
   end
endmodule

// ===== verilog/fsf_ost.v
// Oscillator start-up timer: counts external clock falling edges.
// Assumes the edge strobe is already synchronised to sys_clk_in.
`timescale 1ns/1ps
`include "fsf_map.vh"

module fsf_ost #(
   parameter CYCLES = `FSF_OST_CYCLES
) (
   input wire sys_clk_in, // System clock
   input wire rst_n_in, // Async reset, active low
   input wire ce_in, // Clock enable
   input wire restart_in, // Restart pulse
   input wire bypass_in, // Skip timer (EC or RC mode)
   input wire edge_in, // External clock falling-edge strobe
   output reg done_out // Timer expired
);

   reg [15:0] cnt_q; // Edges seen since restart

   // ----------------------------------------
   // Edge counter
   // ----------------------------------------
   // Counting oscillator edges, not sys clocks, proves the crystal runs
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 16'h0000;
         done_out <= 1'b0;
      end else if (ce_in) begin
         if (restart_in) begin
            cnt_q <= 16'h0000;
            done_out <= bypass_in;
         end else if (bypass_in) begin
            done_out <= 1'b1;
         end else if (!done_out && edge_in) begin
            if (cnt_q == CYCLES[15:0] - 16'h0001) begin
               done_out <= 1'b1;
            end
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule

// ===== verilog/fsf_top.v
// Fail-safe clock monitor start-up gating plus the second peripheral
// interrupt flag register, reached over a plain register port.
// Assumes ext_clk_in and the lf oscillator are asynchronous pins and
// that the other flag sources are one-cycle pulses on sys_clk_in.
`timescale 1ns/1ps
`include "fsf_map.vh"

module fsf_top #(
   parameter OST_CYCLES = `FSF_OST_CYCLES,
   parameter SAMPLE_DIV = `FSF_SAMPLE_DIV
) (
   input wire sys_clk_in, // System clock, 10 MHz
   input wire rst_n_in, // Async reset, active low
   input wire ce_in, // Clock enable, freezes state when low
   input wire [3:0] addr_in, // Register address
   input wire [7:0] wdata_in, // Write data
   input wire wr_in, // Write strobe
   input wire rd_in, // Read strobe
   output reg [7:0] rdata_out, // Read data, cycle after read
   output reg irq_out, // Level interrupt
   input wire ext_clk_in, // External oscillator pin
   input wire lf_osc_in, // Low-frequency internal oscillator
   input wire [1:0] osc_mode_in, // 0 crystal,1 EC,2 RC,3 reserved
   input wire wake_in, // Wake from sleep pulse
   input wire sleep_in, // Sleep executed pulse
   input wire cmp_two_in, // Comparator two event
   input wire cmp_one_in, // Comparator one event
   input wire nvm_done_in, // Nvm write done event
   input wire bus_coll_in, // Serial bus collision event
   input wire ccp_two_in, // Capture/compare two event
   output reg use_internal_out, // System clock from internal source
   output reg fail_out // Fail-safe condition active
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Last divider count of a sample half-cycle; a bare part-select of 64 would be zero
   localparam integer HALF_LAST_I = SAMPLE_DIV / 2 - 1;
   localparam [5:0] HALF_LAST = HALF_LAST_I[5:0];
   reg [1:0] ext_sync_q; // External clock synchroniser
   reg [1:0] lf_sync_q; // Lf oscillator synchroniser
   reg ext_prev_q; // Previous synced external level
   reg lf_prev_q; // Previous synced lf level
   reg [5:0] div_q; // Lf divider for sample clock
   reg sample_q; // Sample clock level
   reg latch_q; // Fail detector latch
   reg [7:0] flags_q; // peripheral_irq_flags_two
   reg [7:0] mask_q; // Interrupt mask
   reg [7:0] ctrl_q; // Monitor enable and clock select
   reg failed_q; // Fail-safe condition
   reg restart_q; // Start-up timer restart pulse
   reg [7:0] flags_d; // Next flag value
   wire ext_fall; // Falling edge of external clock
   wire lf_rise; // Rising edge of lf oscillator
   wire bypass; // Mode without start-up timer
   wire ost_done; // Start-up timer expired
   wire mon_active; // Monitor is watching
   wire sample_rise; // Sample clock rising edge
   wire sample_fall; // Sample clock falling edge
   wire [7:0] events; // Hardware set terms
   wire [7:0] status; // Status register view
   wire scs_wr; // Write that changes the clock select

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Edge detect reads only the second stage, never the first
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_sync_q <= 2'b00;
         lf_sync_q <= 2'b00;
         ext_prev_q <= 1'b0;
         lf_prev_q <= 1'b0;
      end else if (ce_in) begin
         ext_sync_q <= {ext_sync_q[0], ext_clk_in};
         lf_sync_q <= {lf_sync_q[0], lf_osc_in};
         ext_prev_q <= ext_sync_q[1];
         lf_prev_q <= lf_sync_q[1];
      end
   end

   assign ext_fall = ext_prev_q & ~ext_sync_q[1];
   assign lf_rise = ~lf_prev_q & lf_sync_q[1];

   // ----------------------------------------
   // Sample clock: lf oscillator divided by 64
   // ----------------------------------------
   // Toggle every half of the division, so a full period is 64 lf clocks
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= 6'h00;
         sample_q <= 1'b0;
      end else if (ce_in && lf_rise) begin
         if (div_q == HALF_LAST) begin
            div_q <= 6'h00;
            sample_q <= ~sample_q;
         end else begin
            div_q <= div_q + 6'h01;
         end
      end
   end

   assign sample_rise = ce_in & lf_rise & ~sample_q &
      (div_q == HALF_LAST);
   assign sample_fall = ce_in & lf_rise & sample_q &
      (div_q == HALF_LAST);

   // ----------------------------------------
   // Start-up timer
   // ----------------------------------------
   assign bypass = (osc_mode_in == 2'b01) | (osc_mode_in == 2'b10);

   fsf_ost #(
      .CYCLES(OST_CYCLES)
   ) u_ost (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .restart_in(restart_q),
      .bypass_in(bypass),
      .edge_in(ext_fall),
      .done_out(ost_done)
   );

   assign mon_active = ctrl_q[`FSF_CTRL_MON_EN] & ost_done & ~restart_q;
   assign scs_wr = wr_in && addr_in == `FSF_ADDR_CTRL &&
      wdata_in[`FSF_CTRL_SCS_HI:`FSF_CTRL_SCS_LO] !=
      ctrl_q[`FSF_CTRL_SCS_HI:`FSF_CTRL_SCS_LO];

   // ----------------------------------------
   // Restart pulse: wake, sleep or select change
   // ----------------------------------------
   // Comes up high out of reset so the timer runs after every reset
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         restart_q <= 1'b1;
      end else if (ce_in) begin
         restart_q <= wake_in | sleep_in | scs_wr;
      end
   end

   // ----------------------------------------
   // Fail detector latch and fail-safe condition
   // ----------------------------------------
   // Latch set by external falling edge, cleared by sample rising edge;
   // a high sample half-cycle ending at the sample falling edge with the latch still clear is a failure
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         latch_q <= 1'b0;
         failed_q <= 1'b0;
      end else if (ce_in) begin
         if (ext_fall) begin
            latch_q <= 1'b1;
         end else if (sample_rise) begin
            latch_q <= 1'b0;
         end
         if (restart_q) begin
            failed_q <= 1'b0;
            latch_q <= 1'b1;
         end else if (mon_active && sample_fall && !latch_q && !ext_fall) begin
            failed_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Clock source outputs
   // ----------------------------------------
   // Internal clock runs code while timer counts when monitor enabled
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         use_internal_out <= 1'b1;
         fail_out <= 1'b0;
      end else if (ce_in) begin
         use_internal_out <= failed_q | (ctrl_q[`FSF_CTRL_MON_EN] & ~ost_done);
         fail_out <= failed_q;
      end
   end

   // ----------------------------------------
   // Flag register
   // ----------------------------------------
   assign events = {failed_q & mon_active, cmp_two_in, cmp_one_in, nvm_done_in,
      bus_coll_in, 2'b00, ccp_two_in};

   // Hardware set beats software write and read-clear in the same cycle
   always @* begin
      flags_d = flags_q;
      if (wr_in && addr_in == `FSF_ADDR_FLAGS) begin
         flags_d = wdata_in;
      end else if (rd_in && addr_in == `FSF_ADDR_STAT) begin
         flags_d = 8'h00;
      end
      flags_d = (flags_d | events) & `FSF_FLAGS_IMPL;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_q <= `FSF_FLAGS_RESET;
         mask_q <= 8'h00;
         ctrl_q <= `FSF_CTRL_RESET;
      end else if (ce_in) begin
         flags_q <= flags_d;
         if (wr_in && addr_in == `FSF_ADDR_MASK) begin
            mask_q <= wdata_in & `FSF_FLAGS_IMPL;
         end
         if (wr_in && addr_in == `FSF_ADDR_CTRL) begin
            ctrl_q <= wdata_in & 8'h07;
         end
      end
   end

   assign status = {4'h0, failed_q, use_internal_out, mon_active, ost_done};

   // ----------------------------------------
   // Read port and interrupt
   // ----------------------------------------
   // Status read (address 3) also clears the flags, but does not return them:
   // the read returns the status view, not the flag value seen before the clear
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
         irq_out <= 1'b0;
      end else if (ce_in) begin
         if (rd_in) begin
            case (addr_in)
               `FSF_ADDR_FLAGS: rdata_out <= flags_q;
               `FSF_ADDR_MASK: rdata_out <= mask_q;
               `FSF_ADDR_CTRL: rdata_out <= ctrl_q;
               `FSF_ADDR_STAT: rdata_out <= status;
               default: rdata_out <= 8'h00;
            endcase
         end else begin
            rdata_out <= 8'h00;
         end
         irq_out <= |(flags_d & mask_q);
      end
   end
endmodule
